// ==== logic/pss_pkg.sv ====
// constants shared by the reference switchover and scan reconfig logic
package pss_pkg;
    localparam int CLK_HZ = 20_000_000;        // system clock rate
    localparam int LOST_NS = 2_000;            // idle time that marks a lost ref
    localparam int LOST_CYC = (LOST_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int LOST_W = 7;                 // width of the idle counter
    localparam logic [LOST_W-1:0] LOST_LIM = LOST_W'(LOST_CYC);
    localparam logic [1:0] HOLD_EDGES = 2'h3;  // ref edges request must stay high
    localparam int CHAIN_SMALL = 180;          // chain length, smaller variant
    localparam int CHAIN_LARGE = 234;          // chain length, larger top/bottom
    localparam int SEG_W = 18;                 // bits per counter block
    localparam logic [3:0] SEG_SMALL = 4'hA;   // blocks in the short chain
    localparam logic [3:0] SEG_LARGE = 4'hD;   // blocks in the long chain
    localparam int N_IN = 10;                  // synchronised input count
    // positions of the synchronised inputs
    localparam int I_PRI = 0;
    localparam int I_BAK = 1;
    localparam int I_SCLK = 2;
    localparam int I_GATE = 3;
    localparam int I_SDAT = 4;
    localparam int I_CMT = 5;
    localparam int I_SWREQ = 6;
    localparam int I_PFD = 7;
    localparam int I_MAN = 8;
    localparam int I_WIDE = 9;
    localparam logic [CHAIN_LARGE-1:0] CFG_RST = '0; // configuration at reset
    typedef enum logic [1:0] {PSS_SW_IDLE, PSS_SW_COUNT, PSS_SW_WAIT} pss_sw_e;
endpackage

// ==== logic/pss_sync_if.sv ====
// carrier for synchronised input levels and their rising edges
`timescale 1ns/1ns
`default_nettype none
interface pss_sync_if;
    logic [pss_pkg::N_IN-1:0] lvl;  // inputs after two flops
    logic [pss_pkg::N_IN-1:0] rise; // one-cycle rising edge marks
    modport src (output lvl, output rise);
    modport dst (input lvl, input rise);
endinterface
`default_nettype wire

// ==== logic/pss_sync.sv ====
// two-flop synchroniser bank with rising edge detect
`timescale 1ns/1ns
`default_nettype none
module pss_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [pss_pkg::N_IN-1:0] async_i,
    pss_sync_if.src sy
);
    logic [pss_pkg::N_IN-1:0] meta; // first stage, read only by stage two
    logic [pss_pkg::N_IN-1:0] stab; // second stage
    logic [pss_pkg::N_IN-1:0] prev; // history for edge detect

    // edge detect looks only at the stable stage
    assign sy.lvl = stab;
    assign sy.rise = stab & ~prev;

    // synchroniser chain
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta <= '0;
            stab <= '0;
            prev <= '0;
        end else begin
            meta <= async_i;
            stab <= meta;
            prev <= stab;
        end
    end
endmodule
`default_nettype wire

// ==== logic/pss_ctrl.sv ====
// reference switchover and serial scan reconfiguration control
`timescale 1ns/1ns
`default_nettype none
module pss_ctrl (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic primary_ref_clock_i,
    input wire logic backup_ref_clock_i,
    input wire logic serial_shift_clock_i,
    input wire logic shift_clock_gate_i,
    input wire logic serial_config_in_i,
    input wire logic config_commit_i,
    input wire logic switch_request_i,
    input wire logic phase_detector_enable_i,
    input wire logic manual_mode_i,
    input wire logic wide_chain_i,
    output logic ref_select_o,
    output logic primary_lost_o,
    output logic backup_lost_o,
    output logic osc_hold_o,
    output logic reconfig_done_o,
    output logic [pss_pkg::CHAIN_LARGE-1:0] active_config_o
);
    pss_sync_if sy ();

    // every outside input passes two flops before use
    pss_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({wide_chain_i, manual_mode_i, phase_detector_enable_i,
                  switch_request_i, config_commit_i, serial_config_in_i,
                  shift_clock_gate_i, serial_shift_clock_i,
                  backup_ref_clock_i, primary_ref_clock_i}),
        .sy(sy)
    );

    // ---- clock sensing ----
    logic [pss_pkg::LOST_W-1:0] idle_cnt [2]; // cycles since last ref edge
    logic [1:0] lost;                         // per-reference lost flags
    wire [1:0] ref_rise = {sy.rise[pss_pkg::I_BAK], sy.rise[pss_pkg::I_PRI]};

    // a reference that shows no edge for the idle limit is lost; the flag
    // only means something while the two refs stay within 2x
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            idle_cnt[0] <= '0;
            idle_cnt[1] <= '0;
            lost <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ref_rise[i]) begin
                    idle_cnt[i] <= '0; // toggling again clears the flag
                    lost[i] <= 1'b0;
                end else if (idle_cnt[i] != pss_pkg::LOST_LIM) begin
                    idle_cnt[i] <= idle_cnt[i] + 1'b1;
                end else begin
                    lost[i] <= 1'b1; // stopped toggling
                end
            end
        end
    end

    assign primary_lost_o = lost[0];
    assign backup_lost_o = lost[1];

    // ---- reference switchover ----
    pss_pkg::pss_sw_e sw_state; // manual request tracker
    logic sel;                  // 0 primary, 1 backup
    logic [1:0] hold_cnt;       // active ref edges seen with request high
    wire swreq = sy.lvl[pss_pkg::I_SWREQ];
    wire manual = sy.lvl[pss_pkg::I_MAN];
    wire act_edge = sel ? ref_rise[1] : ref_rise[0];
    wire target_ok = sel ? !lost[0] : !lost[1];
    wire held = (hold_cnt == pss_pkg::HOLD_EDGES);
    // automatic flip only when the request does not override it
    wire auto_flip = !manual && !swreq && (sel ? lost[1] : lost[0])
                     && target_ok;

    // a held request toggles the reference; no frequency check is made,
    // so refs far apart are allowed and relock is the user's concern
    // a request rising on a stopped clock is not detected here
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sw_state <= pss_pkg::PSS_SW_IDLE;
            sel <= 1'b0; // primary by default
            hold_cnt <= 2'h0;
        end else begin
            unique case (sw_state)
                pss_pkg::PSS_SW_IDLE: begin
                    hold_cnt <= 2'h0;
                    if (sy.rise[pss_pkg::I_SWREQ]) begin
                        sw_state <= pss_pkg::PSS_SW_COUNT;
                    end else if (auto_flip) begin
                        sel <= !sel;
                    end
                end
                pss_pkg::PSS_SW_COUNT: begin
                    if (!swreq) begin
                        sw_state <= pss_pkg::PSS_SW_IDLE; // too short
                    end else if (held && target_ok) begin
                        sel <= !sel; // toggle after three edges
                        sw_state <= pss_pkg::PSS_SW_WAIT;
                    end else if (act_edge && !held) begin
                        hold_cnt <= hold_cnt + 1'b1;
                    end
                end
                pss_pkg::PSS_SW_WAIT: begin
                    // request must fall before another event
                    if (!swreq) begin
                        sw_state <= pss_pkg::PSS_SW_IDLE;
                    end
                end
            endcase
        end
    end

    assign ref_select_o = sel;

    // phase detector off freezes the oscillator control
    assign osc_hold_o = !sy.lvl[pss_pkg::I_PFD];

    // ---- scan chain ----
    logic [pss_pkg::CHAIN_LARGE-1:0] chain; // serial shift register
    logic armed;                            // first gated edge seen
    logic cmt_q;                            // commit at previous shift edge
    logic wide;                             // long chain variant
    wire sclk_rise = sy.rise[pss_pkg::I_SCLK];
    wire gate = sy.lvl[pss_pkg::I_GATE];
    wire sdat = sy.lvl[pss_pkg::I_SDAT];
    wire cmt = sy.lvl[pss_pkg::I_CMT];
    wire commit_go = sclk_rise && cmt && !cmt_q;

    // the variant strap is caught by a clocked process, not by reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wide <= 1'b0;
        end else begin
            wide <= sy.lvl[pss_pkg::I_WIDE];
        end
    end

    // shift only on gated shift clock edges; the edge after the gate
    // rises is skipped, so data counts from the second one
    // the sender must raise the gate a cycle early and drop it
    // after the chain length the sync delay stays under the
    // slow shift clock's half period
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            chain <= '0;
            armed <= 1'b0;
            cmt_q <= 1'b0;
        end else begin
            if (sclk_rise) begin
                cmt_q <= cmt;
            end
            if (!gate) begin
                armed <= 1'b0;
            end else if (sclk_rise) begin
                if (!armed) begin
                    armed <= 1'b1;
                end else if (wide) begin
                    // long chain: first bit ends in bit 0
                    chain <= {sdat, chain[pss_pkg::CHAIN_LARGE-1:1]};
                end else begin
                    // short chain: first bit ends in the top index
                    chain <= {chain[pss_pkg::CHAIN_LARGE-2:0], sdat};
                end
            end
        end
    end

    // ---- apply configuration ----
    logic [pss_pkg::CHAIN_LARGE-1:0] staged; // chain copy taken at commit
    logic [pss_pkg::CHAIN_LARGE-1:0] active; // configuration in use
    logic applying;                          // update in progress
    logic [3:0] seg;                         // block being updated
    wire [3:0] seg_n = wide ? pss_pkg::SEG_LARGE : pss_pkg::SEG_SMALL;
    // short chain sits in the low bits after left shifting
    wire [pss_pkg::CHAIN_LARGE-1:0] chain_view = chain;

    // one block per cycle so the counters change at different instants,
    // mirroring each counter updating on its own clock the
    // covered fields are all counters, pump and filter bits
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            staged <= '0;
            active <= pss_pkg::CFG_RST;
            applying <= 1'b0;
            seg <= 4'h0;
        end else if (applying) begin
            active[seg * pss_pkg::SEG_W +: pss_pkg::SEG_W] <=
                staged[seg * pss_pkg::SEG_W +: pss_pkg::SEG_W];
            if (seg == seg_n - 4'h1) begin
                applying <= 1'b0; // all seg_n blocks of this variant hold new values
                seg <= 4'h0;
            end else begin
                seg <= seg + 4'h1;
            end
        end else if (commit_go) begin
            // commits during an update are ignored; until one arrives the
            // active setting is untouched by shifting
            staged <= chain_view;
            applying <= 1'b1; // done rises while reconfiguring
        end
    end

    assign reconfig_done_o = applying;
    assign active_config_o = active;

    // reset after switchover and clock gating until lock
    // are kept by the user logic around this block
endmodule
`default_nettype wire

// ==== testbench/pss_sva.sv ====
// port checks for the switchover and scan reconfig control
`timescale 1ns/1ns
`default_nettype none
module pss_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic primary_ref_clock_i,
    input wire logic config_commit_i,
    input wire logic switch_request_i,
    input wire logic phase_detector_enable_i,
    input wire logic ref_select_o,
    input wire logic primary_lost_o,
    input wire logic backup_lost_o,
    input wire logic osc_hold_o,
    input wire logic reconfig_done_o,
    input wire logic [pss_pkg::CHAIN_LARGE-1:0] active_config_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic prev; // primary pin one clock ago
    logic [6:0] idle; // quiet clocks on the primary pin, saturating
    // margin over the 41 quiet clocks covers the input synchroniser
    always_ff @(posedge clk_i) begin
        prev <= primary_ref_clock_i;
        if (!rstn_i || prev != primary_ref_clock_i) idle <= 7'h00;
        else if (idle != 7'h7F) idle <= idle + 7'h01;
    end
    sequence s_busy; reconfig_done_o[*8]; endsequence
    property p_len;
        $rose(reconfig_done_o) |-> s_busy ##[1:6] !reconfig_done_o;
    endproperty
    a_len: assert property (p_len)
        else $error("apply window length wrong");
    property p_cause; $rose(reconfig_done_o) |-> $past(config_commit_i, 4);
    endproperty
    a_cause: assert property (p_cause)
        else $error("apply started without commit");
    property p_keep; $changed(active_config_o) |->
        reconfig_done_o || $past(reconfig_done_o); endproperty
    a_keep: assert property (p_keep)
        else $error("active config moved outside apply");
    property p_hold_on;
        $fell(phase_detector_enable_i) |-> ##[1:4] osc_hold_o; endproperty
    a_hold_on: assert property (p_hold_on)
        else $error("oscillator hold not raised");
    property p_hold_off;
        $rose(phase_detector_enable_i) |-> ##[1:4] !osc_hold_o; endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("oscillator hold not released");
    property p_sel; $changed(ref_select_o) |-> $past(switch_request_i)
        || primary_lost_o || backup_lost_o; endproperty
    a_sel: assert property (p_sel)
        else $error("reference changed without cause");
    property p_sel_rst; $rose(rstn_i) |-> !ref_select_o; endproperty
    a_sel_rst: assert property (p_sel_rst)
        else $error("primary not selected after reset");
    property p_lost; idle == 7'h34 |-> primary_lost_o; endproperty
    a_lost: assert property (p_lost)
        else $error("stopped primary not flagged");
    property p_found; primary_lost_o && $rose(primary_ref_clock_i)
        |-> ##[1:5] !primary_lost_o; endproperty
    a_found: assert property (p_found)
        else $error("lost flag stuck after edge");
endmodule
`default_nettype wire

// ==== testbench/pss_far.sv ====
// reconfiguration controller model on the scan pins
`timescale 1ns/1ns
`default_nettype none
module pss_far (
    output logic serial_shift_clock_o,
    output logic shift_clock_gate_o,
    output logic serial_config_in_o,
    output logic config_commit_o
);
    // one 400 ns shift cycle; the clock rests low between frames
    // edges land on system clock edges, so drive them non-blocking to
    // keep the synchroniser's sampling free of races
    task automatic tick();
        #200 serial_shift_clock_o <= 1'b1;
        #200 serial_shift_clock_o <= 1'b0;
    endtask
    // whole chain, first bit chosen by the variant
    task automatic shift(input logic [233:0] v, input bit wide);
        int i;
        shift_clock_gate_o <= 1'b1;
        tick(); // spare cycle before data
        for (i = 0; i < (wide ? 234 : 180); i++) begin
            serial_config_in_o <= wide ? v[i] : v[179 - i];
            tick();
        end
        shift_clock_gate_o <= 1'b0; // full length shifted
    endtask
    // commit held over two shift cycles
    task automatic commit();
        config_commit_o <= 1'b1;
        tick();
        tick();
        config_commit_o <= 1'b0;
    endtask
    // ungated clocks with a changing data line must not shift
    task automatic junk(input int n);
        repeat (n) begin
            serial_config_in_o <= ~serial_config_in_o;
            tick();
        end
    endtask
    initial begin
        {serial_shift_clock_o, shift_clock_gate_o} = 2'h0;
        {serial_config_in_o, config_commit_o} = 2'h0;
    end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for switchover and scan reconfig
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int W = pss_pkg::CHAIN_LARGE;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic pri = 1'b0, bak = 1'b0, req = 1'b0, pfd = 1'b1, man = 1'b0;
    logic wide = 1'b0, pri_run = 1'b1, bak_run = 1'b1;
    logic [3:0] pdiv = 4'h0, bdiv = 4'h0, bhalf = 4'h2;
    logic sclk, gate, sdat, cmt, sel, plost, blost, hold, done;
    logic [W-1:0] cfg, v;
    int err_count = 0;
    int tests_run = 0;
    int n;
    always #25 clk_i = ~clk_i;
    // both references keep running unless a test stops one
    always @(posedge clk_i) begin
        pdiv <= (pdiv == 4'h1) ? 4'h0 : pdiv + 4'h1;
        bdiv <= (bdiv >= bhalf) ? 4'h0 : bdiv + 4'h1;
        if (pri_run && pdiv == 4'h1) pri <= ~pri;
        if (bak_run && bdiv >= bhalf) bak <= ~bak;
    end
    pss_far u_far (.serial_shift_clock_o(sclk), .shift_clock_gate_o(gate),
        .serial_config_in_o(sdat), .config_commit_o(cmt));
    pss_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .primary_ref_clock_i(pri),
        .backup_ref_clock_i(bak), .serial_shift_clock_i(sclk),
        .shift_clock_gate_i(gate), .serial_config_in_i(sdat),
        .config_commit_i(cmt), .switch_request_i(req),
        .phase_detector_enable_i(pfd), .manual_mode_i(man),
        .wide_chain_i(wide), .ref_select_o(sel), .primary_lost_o(plost),
        .backup_lost_o(blost), .osc_hold_o(hold), .reconfig_done_o(done),
        .active_config_o(cfg));
    task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // short chains only replace the low blocks
    function automatic logic [W-1:0] exp_cfg(input logic [W-1:0] old,
        input logic [W-1:0] nv, input bit wd);
        exp_cfg = wd ? nv : {old[W-1:180], nv[179:0]};
    endfunction
    // shift, idle clocks, commit, then time the apply window
    task automatic reconfig(input logic [W-1:0] nv, input bit wd);
        logic [W-1:0] old;
        old = cfg;
        @(posedge clk_i) wide <= wd;
        u_far.shift(nv, wd);
        u_far.junk(3);
        #1 chk(cfg, old);
        fork
            u_far.commit();
            begin
                n = 0;
                while (done !== 1'b1 && n < 60) begin
                    @(posedge clk_i);
                    #1 n++;
                end
                n = 0;
                while (done === 1'b1 && n < 60) begin
                    @(posedge clk_i);
                    #1 n++;
                end
            end
        join
        chk(W'(n), W'(wd ? pss_pkg::SEG_LARGE : pss_pkg::SEG_SMALL));
        chk(cfg, exp_cfg(old, nv, wd));
    endtask
    task automatic pulse_req(input int len);
        @(posedge clk_i) req <= 1'b1;
        repeat (len) @(posedge clk_i);
        req <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
    endtask
    initial begin
        n = $urandom(99);
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 chk(W'(sel), W'(0));
        chk(cfg, pss_pkg::CFG_RST);
        for (int k = 0; k < 4; k++) begin
            v = W'({$urandom, $urandom, $urandom, $urandom, $urandom,
                $urandom, $urandom, $urandom});
            if (k == 0) v = '1;
            reconfig(v, k[0]);
        end
        @(posedge clk_i) man <= 1'b1;
        bhalf <= 4'h5; // backup three times slower than primary
        pulse_req(48);
        chk(W'(sel), W'(1));
        pulse_req(48);
        chk(W'(sel), W'(0));
        pulse_req(2);
        chk(W'(sel), W'(0));
        pulse_req(48);
        chk(W'(sel), W'(1));
        // reset held far beyond 10 ns after the switch
        @(posedge clk_i) rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        // outputs only trusted once the block has settled again
        repeat (4) @(posedge clk_i);
        #1 chk(W'(sel), W'(0));
        chk(cfg, pss_pkg::CFG_RST);
        @(posedge clk_i) man <= 1'b0;
        bhalf <= 4'h2;
        repeat (20) @(posedge clk_i);
        pri_run <= 1'b0;
        repeat (60) @(posedge clk_i);
        #1 chk(W'({plost, blost, sel}), W'(3'h5));
        @(posedge clk_i) pri_run <= 1'b1;
        repeat (10) @(posedge clk_i);
        #1 chk(W'(plost), W'(0));
        // stopping the active backup flips back to the primary
        @(posedge clk_i) bak_run <= 1'b0;
        repeat (60) @(posedge clk_i);
        #1 chk(W'({plost, blost, sel}), W'(3'h2));
        @(posedge clk_i) bak_run <= 1'b1;
        repeat (14) @(posedge clk_i);
        #1 chk(W'(blost), W'(0));
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i) pfd <= k[0];
            repeat (5) @(posedge clk_i);
            #1 chk(W'(hold), W'(!k[0]));
        end
        end_of_test();
    end
    // cut a hang well past the expected run length
    initial begin
        #2_000_000;
        err_count++;
        end_of_test();
    end
endmodule
bind pss_ctrl pss_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .primary_ref_clock_i(primary_ref_clock_i),
    .config_commit_i(config_commit_i), .switch_request_i(switch_request_i),
    .phase_detector_enable_i(phase_detector_enable_i),
    .ref_select_o(ref_select_o), .primary_lost_o(primary_lost_o),
    .backup_lost_o(backup_lost_o), .osc_hold_o(osc_hold_o),
    .reconfig_done_o(reconfig_done_o), .active_config_o(active_config_o));
`default_nettype wire
